// file: hw/axis_sup_map.vh
// Constants for the axis supervision block
`ifndef AXIS_SUP_MAP_VH
`define AXIS_SUP_MAP_VH
`define FULLSTEP_DEFAULT      16'd200
`define USTEP_RES_DEFAULT     4'h8
`define USTEP_RES_256         4'h8
`define UNIT_MODE_DEFAULT     1'b1
`define PD_DELAY_DEFAULT      8'hc8
`define PD_TICK_MS            10
`define CLK_KHZ               10000
`define PD_TICK_CYCLES        (`PD_TICK_MS * `CLK_KHZ)
`define FLOOR_HALF            1'b0
`define FLOOR_QUARTER         1'b1
`define CUR_STEP_SHIFT        3
`define CUR_MAX               8'hff
`define ENC_IDX_CLR_BIT       0
`define LOAD_FULL_SCALE       10'h3ff
`define VEL_NATIVE_SHIFT      4'h4
`endif

// file: hw/enc_scaler.v
// Encoder count to microstep position scaler
`timescale 1ns/1ps
module enc_scaler (
    input  wire [31:0] enc_count_i,
    input  wire [15:0] enc_cpr_i,
    input  wire [15:0] fullsteps_i,
    input  wire [3:0]  ustep_res_i,
    output wire [31:0] enc_pos_o
);
    wire [15:0] ustep_per_fs = 16'h0001 << ustep_res_i;
    wire [31:0] ustep_per_rev = fullsteps_i * ustep_per_fs;
    wire signed [63:0] prod = $signed(enc_count_i) * $signed({1'b0, ustep_per_rev});
    wire signed [63:0] quot = (enc_cpr_i == 16'h0000) ? prod :
                              prod / $signed({48'h0, enc_cpr_i});
    assign enc_pos_o = quot[31:0];
endmodule

// file: hw/axis_supervisor.v
// Stepper axis supervision: encoder, stall stop, load-adaptive current, standby
`timescale 1ns/1ps
`include "axis_sup_map.vh"
// Behaviour
// RULE1: Encoder counts rescaled by counts per rev and full steps to microsteps.
// RULE2: Encoder position readable and writable to load a new origin.
// RULE3: Reference search completion loads zero into encoder position.
// RULE4: Deviation-stop enabled stops motor when encoder cannot follow command.
// RULE5: Special function setting clears encoder position on index pulse.
// RULE6: Load value falls linearly with load, zero at maximum load.
// RULE7: Stall stop when speed above setting and load reaches zero.
// RULE8: Load-adaptive regulation active only above threshold speed.
// RULE9: Current floor is half (0) or quarter (1) of run current.
// RULE10: Decrement after 32, 8, 2 or 1 readings above upper threshold.
// RULE11: Each reading below lower threshold raises current by 1, 2, 4, 8.
// RULE12: Upper threshold equals lower threshold plus hysteresis.
// RULE13: Current 0..255 resolved into 32 steps of eight values.
// RULE14: Standby current after standstill delay in 10 ms units.
// RULE15: Unit mode 1 treats velocities as microsteps per second.
// RULE16: Unit mode 0 passes velocities as native ramp units.
// RULE17: Microstep resolution defaults to 256, setting 8, used in scaling.
// RULE18: Regulated current clamped between floor and run current, restored when idle.
module axis_supervisor #(
    parameter [23:0] PD_TICK = `PD_TICK_CYCLES
) (
    input  wire        core_clk_i,
    input  wire        rst_i,
    input  wire        enc_a_i,
    input  wire        enc_b_i,
    input  wire        enc_idx_i,
    input  wire [15:0] enc_cpr_i,
    input  wire [15:0] fullsteps_i,
    input  wire [3:0]  ustep_res_i,
    input  wire        enc_pos_wr_i,
    input  wire [31:0] enc_pos_wdata_i,
    input  wire        ref_search_done_i,
    input  wire [7:0]  encoder_function_i,
    input  wire [31:0] deviation_limit_i,
    input  wire [31:0] motor_pos_i,
    input  wire [9:0]  load_raw_i,
    input  wire        load_valid_i,
    input  wire [23:0] actual_speed_i,
    input  wire [23:0] stall_stop_speed_i,
    input  wire [23:0] regulation_threshold_speed_i,
    input  wire        regulator_current_floor_i,
    input  wire [1:0]  current_decrement_rate_i,
    input  wire [1:0]  current_increment_rate_i,
    input  wire [9:0]  current_threshold_setting_i,
    input  wire [9:0]  load_threshold_hysteresis_i,
    input  wire [7:0]  run_current_level_i,
    input  wire [7:0]  standby_current_level_i,
    input  wire [7:0]  standstill_powerdown_delay_i,
    input  wire        unit_mode_i,
    input  wire [23:0] vel_setting_i,
    input  wire [23:0] acc_setting_i,
    output reg  [31:0] enc_pos_o,
    output reg  [9:0]  load_value_o,
    output reg         motor_stop_o,
    output reg         deviation_stop_o,
    output reg         stall_stop_o,
    output reg  [4:0]  current_step_o,
    output reg         regulation_active_o,
    output reg         standby_o,
    output reg  [23:0] ramp_vel_o,
    output reg  [23:0] ramp_acc_o
);
    localparam ST_RUN     = 3'b001;
    localparam ST_WAIT    = 3'b010;
    localparam ST_STANDBY = 3'b100;

    function [7:0] sat_add;
        input [7:0] a;
        input [3:0] b;
        reg   [8:0] s;
        begin
            s = {1'b0, a} + {5'h00, b};
            sat_add = s[8] ? 8'hff : s[7:0];
        end
    endfunction

    function [4:0] to_step;
        input [7:0] cur;
        begin
            to_step = cur[7:`CUR_STEP_SHIFT];
        end
    endfunction

    // Input synchronisers
    reg [2:0] a_s1;
    reg [2:0] a_s2;
    reg       a_q, b_q, idx_q;
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            a_s1 <= 3'h0;
            a_s2 <= 3'h0;
            a_q  <= 1'b0;
            b_q  <= 1'b0;
            idx_q <= 1'b0;
        end else begin
            a_s1 <= {enc_idx_i, enc_b_i, enc_a_i};
            a_s2 <= a_s1;
            a_q  <= a_s2[0];
            b_q  <= a_s2[1];
            idx_q <= a_s2[2];
        end
    end
    wire a_now = a_s2[0];
    wire b_now = a_s2[1];
    wire idx_rise = a_s2[2] & ~idx_q;
    wire step_ev = (a_now ^ a_q) | (b_now ^ b_q);
    wire dir_up = a_q ^ b_now;

    // Quadrature count
    reg [31:0] enc_cnt_r;
    wire [31:0] scaled_pos;
    enc_scaler u_scaler (
        .enc_count_i (enc_cnt_r),
        .enc_cpr_i   (enc_cpr_i),
        .fullsteps_i (fullsteps_i),
        .ustep_res_i (ustep_res_i),
        .enc_pos_o   (scaled_pos)
    );
    // Inverse for a write of a microstep origin
    wire [15:0] ustep_pf = 16'h0001 << ustep_res_i;
    wire [31:0] ustep_rev = fullsteps_i * ustep_pf;
    wire signed [63:0] wr_prod = $signed(enc_pos_wdata_i) * $signed({48'h0, enc_cpr_i});
    wire signed [63:0] wr_cnt = (ustep_rev == 32'h0) ? wr_prod :
                                wr_prod / $signed({1'b0, ustep_rev});

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            enc_cnt_r <= 32'h0;
        end else if (ref_search_done_i) begin
            enc_cnt_r <= 32'h0; // RULE3
        end else if (enc_pos_wr_i) begin
            enc_cnt_r <= wr_cnt[31:0]; // RULE2
        end else if (encoder_function_i[`ENC_IDX_CLR_BIT] && idx_rise) begin
            enc_cnt_r <= 32'h0; // RULE5
        end else if (step_ev) begin
            enc_cnt_r <= dir_up ? enc_cnt_r + 32'h1 : enc_cnt_r - 32'h1;
        end
    end

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            enc_pos_o <= 32'h0;
        end else begin
            enc_pos_o <= scaled_pos; // RULE1
        end
    end

    // Deviation check
    wire [31:0] dev = motor_pos_i - scaled_pos;
    wire [31:0] dev_abs = dev[31] ? (32'h0 - dev) : dev;
    wire dev_trip = (deviation_limit_i != 32'h0) && (dev_abs > deviation_limit_i);

    // Load value and stall
    wire stall_trip = (actual_speed_i > stall_stop_speed_i) && load_valid_i &&
                      (load_raw_i == 10'h000);
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            load_value_o     <= `LOAD_FULL_SCALE;
            deviation_stop_o <= 1'b0;
            stall_stop_o     <= 1'b0;
            motor_stop_o     <= 1'b0;
        end else begin
            if (load_valid_i) begin
                load_value_o <= load_raw_i; // RULE6
            end
            deviation_stop_o <= dev_trip; // RULE4
            stall_stop_o     <= stall_trip; // RULE7
            motor_stop_o     <= dev_trip | stall_trip;
        end
    end

    // Load-adaptive current
    wire reg_on = actual_speed_i > regulation_threshold_speed_i; // RULE8
    wire [7:0] floor_cur = regulator_current_floor_i ? {2'b00, run_current_level_i[7:2]}
                                                     : {1'b0, run_current_level_i[7:1]}; // RULE9
    wire [10:0] upper_thr = {1'b0, current_threshold_setting_i} +
                            {1'b0, load_threshold_hysteresis_i}; // RULE12
    reg [5:0] dec_need;
    always @* begin
        case (current_decrement_rate_i)
            2'd0:    dec_need = 6'd32;
            2'd1:    dec_need = 6'd8;
            2'd2:    dec_need = 6'd2;
            default: dec_need = 6'd1;
        endcase
    end
    wire [3:0] inc_step = 4'h1 << current_increment_rate_i; // RULE11
    reg  [7:0] reg_cur_r;
    reg  [7:0] reg_cur_nxt;
    reg  [5:0] dec_cnt_r;
    reg  [5:0] dec_cnt_nxt;
    always @* begin
        reg_cur_nxt = reg_cur_r;
        dec_cnt_nxt = dec_cnt_r;
        if (!reg_on) begin
            reg_cur_nxt = run_current_level_i; // RULE18
            dec_cnt_nxt = 6'd0;
        end else if (load_valid_i) begin
            if (load_raw_i < current_threshold_setting_i) begin
                reg_cur_nxt = sat_add(reg_cur_r, inc_step); // RULE11
                dec_cnt_nxt = 6'd0;
            end else if ({1'b0, load_raw_i} > upper_thr) begin
                if (dec_cnt_r + 6'd1 >= dec_need) begin
                    dec_cnt_nxt = 6'd0;
                    reg_cur_nxt = (reg_cur_r >= 8'd8) ? reg_cur_r - 8'd8 : 8'd0; // RULE10
                end else begin
                    dec_cnt_nxt = dec_cnt_r + 6'd1;
                end
            end
        end
        if (reg_on) begin
            if (reg_cur_nxt > run_current_level_i) begin
                reg_cur_nxt = run_current_level_i; // RULE18
            end else if (reg_cur_nxt < floor_cur) begin
                reg_cur_nxt = floor_cur; // RULE18
            end
        end
    end
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_cur_r <= 8'h0;
            dec_cnt_r <= 6'd0;
        end else begin
            reg_cur_r <= reg_cur_nxt;
            dec_cnt_r <= dec_cnt_nxt;
        end
    end

    // Standstill power-down
    reg [2:0]  pd_state_r;
    reg [23:0] tick_cnt_r;
    reg [7:0]  pd_cnt_r;
    wire still = (actual_speed_i == 24'h0);
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pd_state_r <= ST_RUN;
            tick_cnt_r <= 24'h0;
            pd_cnt_r   <= 8'h0;
        end else begin
            case (pd_state_r)
                ST_RUN: begin
                    tick_cnt_r <= 24'h0;
                    pd_cnt_r   <= 8'h0;
                    if (still) begin
                        pd_state_r <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (!still) begin
                        pd_state_r <= ST_RUN;
                    end else if (pd_cnt_r >= standstill_powerdown_delay_i) begin
                        pd_state_r <= ST_STANDBY; // RULE14
                    end else if (tick_cnt_r >= PD_TICK - 24'h1) begin
                        tick_cnt_r <= 24'h0;
                        pd_cnt_r   <= pd_cnt_r + 8'h1;
                    end else begin
                        tick_cnt_r <= tick_cnt_r + 24'h1;
                    end
                end
                ST_STANDBY: begin
                    if (!still) begin
                        pd_state_r <= ST_RUN;
                    end
                end
                default: pd_state_r <= ST_RUN;
            endcase
        end
    end

    wire [7:0] cur_sel = (pd_state_r == ST_STANDBY) ? standby_current_level_i :
                         (reg_on ? reg_cur_nxt : run_current_level_i);
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            current_step_o      <= 5'h0;
            regulation_active_o <= 1'b0;
            standby_o           <= 1'b0;
        end else begin
            current_step_o      <= to_step(cur_sel); // RULE13
            regulation_active_o <= reg_on;
            standby_o           <= (pd_state_r == ST_STANDBY);
        end
    end

    // Velocity units
    wire [3:0] res_eff = ustep_res_i;
    wire [4:0] vshift = {1'b0, `VEL_NATIVE_SHIFT} + {1'b0, `USTEP_RES_256 - res_eff};
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ramp_vel_o <= 24'h0;
            ramp_acc_o <= 24'h0;
        end else if (unit_mode_i) begin
            ramp_vel_o <= vel_setting_i >> vshift; // RULE15 RULE17
            ramp_acc_o <= acc_setting_i >> vshift; // RULE15
        end else begin
            ramp_vel_o <= vel_setting_i; // RULE16
            ramp_acc_o <= acc_setting_i; // RULE16
        end
    end
endmodule

// file: testbench/axis_sup_asserts.sv
// Concurrent checks on the axis supervisor ports
`timescale 1ns/1ps
module axis_sup_asserts (
    input wire        core_clk_i,
    input wire        rst_i,
    input wire [9:0]  load_raw_i,
    input wire        load_valid_i,
    input wire [23:0] actual_speed_i,
    input wire [23:0] stall_stop_speed_i,
    input wire [23:0] regulation_threshold_speed_i,
    input wire [7:0]  run_current_level_i,
    input wire [31:0] deviation_limit_i,
    input wire        unit_mode_i,
    input wire [3:0]  ustep_res_i,
    input wire [23:0] vel_setting_i,
    input wire [23:0] acc_setting_i,
    input wire [9:0]  load_value_o,
    input wire        motor_stop_o,
    input wire        deviation_stop_o,
    input wire        stall_stop_o,
    input wire [4:0]  current_step_o,
    input wire        regulation_active_o,
    input wire        standby_o,
    input wire [23:0] ramp_vel_o,
    input wire [23:0] ramp_acc_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    AST_LOAD_CAPTURE: assert property (load_valid_i |=> load_value_o == $past(load_raw_i))
        else $error("load value not captured");
    AST_STALL_STOP: assert property (load_valid_i && load_raw_i == 10'h0 &&
        actual_speed_i > stall_stop_speed_i |=> stall_stop_o) else $error("stall stop missing");
    AST_STALL_BELOW: assert property ($rose(stall_stop_o) |->
        $past(actual_speed_i) > $past(stall_stop_speed_i))
        else $error("stall stop below speed");
    AST_MOTOR_STOP: assert property (stall_stop_o || deviation_stop_o |-> motor_stop_o)
        else $error("motor not stopped");
    AST_DEV_OFF: assert property ($rose(deviation_stop_o) |->
        $past(deviation_limit_i) != 32'h0) else $error("deviation stop while off");
    AST_REG_SPEED: assert property (regulation_active_o |->
        $past(actual_speed_i) > $past(regulation_threshold_speed_i))
        else $error("regulation too slow");
    AST_CUR_CEIL: assert property ($stable(run_current_level_i) && !standby_o |->
        current_step_o <= run_current_level_i[7:3]) else $error("current above run level");
    AST_NATIVE_VEL: assert property (!unit_mode_i |=> ramp_vel_o == $past(vel_setting_i) &&
        ramp_acc_o == $past(acc_setting_i)) else $error("native units altered");
    AST_USTEP_VEL: assert property (unit_mode_i && ustep_res_i == 4'h8 |=>
        ramp_vel_o == ($past(vel_setting_i) >> 4)) else $error("velocity scaling wrong");
    AST_STANDBY_ENTRY: assert property ($rose(standby_o) |->
        $past(actual_speed_i) == 24'h0) else $error("standby while moving");
endmodule
bind axis_supervisor axis_sup_asserts u_chk (.*);

// file: testbench/axis_partner.sv
// Encoder pins and load reading source at the far side of the axis
`timescale 1ns/1ps
module axis_partner (
    input  wire       clk_i,
    output reg        a_o,
    output reg        b_o,
    output reg        idx_o,
    output reg  [9:0] raw_o,
    output reg        valid_o
);
    initial begin
        a_o = 1'b0;
        b_o = 1'b0;
        idx_o = 1'b0;
        raw_o = 10'h155;
        valid_o = 1'b0;
    end
    // Forward quadrature step, B leads A
    task step_fwd;
        begin
            @(posedge clk_i);
            if (a_o == b_o) b_o <= ~b_o;
            else a_o <= ~a_o;
            repeat (3) @(posedge clk_i);
        end
    endtask
    task index_pulse;
        begin
            @(posedge clk_i) idx_o <= 1'b1;
            repeat (3) @(posedge clk_i);
            idx_o <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
    endtask
    // One load reading, data scrambled once released
    task reading(input [9:0] v);
        begin
            @(posedge clk_i);
            raw_o <= v;
            valid_o <= 1'b1;
            @(posedge clk_i);
            valid_o <= 1'b0;
            raw_o <= ~v;
            repeat (2) @(posedge clk_i);
        end
    endtask
endmodule

// file: testbench/tb_top.sv
// Self-checking testbench for the axis supervisor
`timescale 1ns/1ps
module tb_top;
    reg         core_clk_i, rst_i, enc_pos_wr_i, ref_search_done_i, unit_mode_i;
    reg         regulator_current_floor_i;
    reg  [1:0]  current_decrement_rate_i, current_increment_rate_i;
    reg  [3:0]  ustep_res_i;
    reg  [7:0]  encoder_function_i, run_current_level_i, standby_current_level_i;
    reg  [7:0]  standstill_powerdown_delay_i;
    reg  [9:0]  current_threshold_setting_i, load_threshold_hysteresis_i;
    reg  [15:0] enc_cpr_i, fullsteps_i;
    reg  [23:0] actual_speed_i, stall_stop_speed_i, regulation_threshold_speed_i;
    reg  [23:0] vel_setting_i, acc_setting_i, v;
    reg  [31:0] enc_pos_wdata_i, deviation_limit_i, motor_pos_i;
    wire        enc_a_i, enc_b_i, enc_idx_i, load_valid_i, motor_stop_o, deviation_stop_o;
    wire        stall_stop_o, regulation_active_o, standby_o;
    wire [4:0]  current_step_o;
    wire [9:0]  load_raw_i, load_value_o;
    wire [23:0] ramp_vel_o, ramp_acc_o;
    wire [31:0] enc_pos_o;
    integer     n_errors, comparisons, k;
    axis_supervisor #(.PD_TICK(24'd4)) dut (.*);
    axis_partner p (.clk_i(core_clk_i), .a_o(enc_a_i), .b_o(enc_b_i), .idx_o(enc_idx_i),
                    .raw_o(load_raw_i), .valid_o(load_valid_i));
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    task check(input [31:0] seen, input [31:0] exp, input [8*12:1] what);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("ERROR %0s expected %0h seen %0h", what, exp, seen);
            end
        end
    endtask
    task stop_test;
        begin
            $display("errors %0d comparisons %0d", n_errors, comparisons);
            if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    task cyc(input integer n);
        begin
            repeat (n) @(posedge core_clk_i);
            #1;
        end
    endtask
    task feed(input [9:0] val, input integer n);
        integer j;
        begin
            for (j = 0; j < n; j = j + 1) p.reading(val);
            #1;
        end
    endtask
    function integer dec_n(input [1:0] c);
        dec_n = (c == 2'd0) ? 32 : (c == 2'd1) ? 8 : (c == 2'd2) ? 2 : 1;
    endfunction
    function [4:0] inc_step(input [1:0] c, input integer m);
        inc_step = (63 + m * (1 << c)) >> 3;
    endfunction
    initial begin
        n_errors = 0;
        comparisons = 0;
        rst_i = 1'b1;
        {enc_pos_wr_i, ref_search_done_i, regulator_current_floor_i} = 3'h0;
        {current_decrement_rate_i, current_increment_rate_i} = 4'h3;
        {encoder_function_i, deviation_limit_i, motor_pos_i} = 72'h0;
        {vel_setting_i, acc_setting_i, enc_pos_wdata_i} = 80'h0;
        unit_mode_i = 1'b1;
        ustep_res_i = 4'h8;
        run_current_level_i = 8'hff;
        standby_current_level_i = 8'h40;
        standstill_powerdown_delay_i = 8'h03;
        current_threshold_setting_i = 10'd100;
        load_threshold_hysteresis_i = 10'd50;
        enc_cpr_i = 16'd12800;
        fullsteps_i = 16'd200;
        actual_speed_i = 24'd1000;
        stall_stop_speed_i = 24'd2000;
        regulation_threshold_speed_i = 24'd500;
        v = $urandom(10457);
        cyc(12);
        rst_i <= 1'b0;
        cyc(2);
        check(load_value_o, 32'h3ff, "load_rst");
        repeat (10) p.step_fwd();
        cyc(3);
        check(enc_pos_o, 32'd40, "enc_scale");
        enc_pos_wr_i <= 1'b1;
        enc_pos_wdata_i <= 32'd1000;
        cyc(1);
        enc_pos_wr_i <= 1'b0;
        repeat (5) p.step_fwd();
        cyc(3);
        check(enc_pos_o, 32'd1020, "enc_write");
        for (k = 0; k < 2; k = k + 1) begin
            encoder_function_i <= k[7:0];
            p.index_pulse();
            cyc(3);
            check(enc_pos_o, k ? 32'd0 : 32'd1020, "enc_index");
        end
        repeat (5) p.step_fwd();
        ref_search_done_i <= 1'b1;
        cyc(1);
        ref_search_done_i <= 1'b0;
        cyc(4);
        check(enc_pos_o, 32'd0, "enc_ref");
        motor_pos_i <= 32'd5000;
        for (k = 0; k < 2; k = k + 1) begin
            deviation_limit_i <= k ? 32'd100 : 32'd0;
            cyc(6);
            check(deviation_stop_o, k, "dev_stop");
            check(motor_stop_o, k, "motor_stop");
        end
        motor_pos_i <= 32'd0;
        deviation_limit_i <= 32'd0;
        check(regulation_active_o, 32'd1, "reg_on");
        feed(10'd50, 20);
        check(current_step_o, 32'd31, "cur_max");
        for (k = 0; k < 4; k = k + 1) begin
            current_decrement_rate_i <= k[1:0];
            feed(10'd50, 2);
            feed(10'd200, dec_n(k) - 1);
            check(current_step_o, 32'd31, "cur_hold");
            feed(10'd200, 1);
            check(current_step_o, 32'd30, "cur_dec");
        end
        for (k = 0; k < 40; k = k + 1) p.reading(10'd101 + $urandom % 49);
        cyc(1);
        check(current_step_o, 32'd30, "cur_band");
        for (k = 0; k < 2; k = k + 1) begin
            regulator_current_floor_i <= k[0];
            feed(10'd200, 40);
            check(current_step_o, k ? 32'd7 : 32'd15, "cur_floor");
        end
        for (k = 0; k < 4; k = k + 1) begin
            current_increment_rate_i <= k[1:0];
            feed(10'd200, 40);
            feed(10'd50, 8);
            check(current_step_o, inc_step(k, 8), "cur_inc");
        end
        v = $urandom;
        actual_speed_i <= 24'd400;
        run_current_level_i <= v[7:0];
        cyc(4);
        check(regulation_active_o, 32'd0, "reg_off");
        check(current_step_o, v[7:3], "cur_run");
        for (k = 0; k < 2; k = k + 1) begin
            v = $urandom;
            unit_mode_i <= k[0];
            vel_setting_i <= v;
            acc_setting_i <= ~v;
            cyc(3);
            check(ramp_vel_o, k ? v >> 4 : v, "ramp_vel");
            check(ramp_acc_o, k ? {8'h0, ~v} >> 4 : {8'h0, ~v}, "ramp_acc");
        end
        actual_speed_i <= 24'd0;
        cyc(10);
        check(standby_o, 32'd0, "standby_wait");
        cyc(6);
        check(standby_o, 32'd1, "standby");
        check(current_step_o, 32'd8, "cur_stby");
        actual_speed_i <= 24'd1000;
        cyc(3);
        check(standby_o, 32'd0, "standby_exit");
        for (k = 0; k < 2; k = k + 1) begin
            stall_stop_speed_i <= k ? 24'd500 : 24'd2000;
            fork
                p.reading(10'd0);
                begin
                    cyc(2);
                    check(load_value_o, 32'd0, "load_zero");
                    check(stall_stop_o, k, "stall");
                    check(motor_stop_o, k, "stall_motor");
                end
            join
        end
        stop_test;
    end
    initial begin
        #(100 * 30000);
        n_errors = n_errors + 1;
        stop_test;
    end
endmodule
